// ==== test/tacl_cpu_model.sv ====
`timescale 1ns/10ps
module tacl_cpu_model
  import tacl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic acc_accept_i,
  output logic acc_req_o,
  output logic acc_we_o,
  output logic [1:0] acc_sel_o,
  output logic [15:0] acc_wdata_o,
  output logic kick_o,
  output logic ext_a_o,
  output logic ext_b_o
);
  initial
  begin
    acc_req_o = 1'b0;
    acc_we_o = 1'b0;
    acc_sel_o = SEL_COUNT;
    acc_wdata_o = 16'h0000;
    kick_o = 1'b0;
    ext_a_o = 1'b0;
    ext_b_o = 1'b0;
  end

  // ==========================================================================
  // Bus cycle
  // ==========================================================================
  // The request stands until the taking edge; kick_o marks the second state.
  task automatic access(input logic we, input logic [1:0] sel, input logic [15:0] wd,
    input logic kick, output logic ok);
    int n;
    ok = 1'b0;
    acc_req_o = 1'b1;
    acc_we_o = we;
    acc_sel_o = sel;
    acc_wdata_o = wd;
    for (n = 0; n < 20 && ok !== 1'b1; n++)
    begin
      @(negedge sys_clk_i);
      ok = acc_accept_i;
    end
    @(posedge sys_clk_i);
    #1;
    acc_req_o = 1'b0;
    acc_we_o = ~we;
    acc_wdata_o = ~wd;
    @(posedge sys_clk_i);
    #1;
    kick_o = kick;
    @(posedge sys_clk_i);
    #1;
    kick_o = 1'b0;
  endtask

  // Each level is held three states, which suits both edge modes.
  task automatic ext_pulses(input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge sys_clk_i);
      #1;
      ext_a_o = ~ext_a_o;
    end
  endtask

  // One input moves every three states, so gap, overlap and width all keep their limits.
  task automatic phase_steps(input int n, input logic up);
    repeat (n)
    begin
      repeat (3) @(posedge sys_clk_i);
      #1;
      if ((ext_a_o == ext_b_o) == up)
        ext_a_o = ~ext_a_o;
      else
        ext_b_o = ~ext_b_o;
    end
  endtask
endmodule

// ==== test/tb_tacl_timer_channel.sv ====
`timescale 1ns/10ps
module tb_tacl_timer_channel;
  import tacl_pkg::*;
  typedef struct packed {logic rd; logic [15:0] v;} tacl_note_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic module_stop = 1'b1;
  logic run = 1'b0;
  logic [1:0] clock_src = SRC_INTERNAL;
  logic clear_match = 1'b0;
  logic cap_mode = 1'b0;
  logic buf_mode = 1'b0;
  logic cmp_en = 1'b1;
  logic ovf_en = 1'b0;
  logic udf_en = 1'b0;
  logic match_en = 1'b0;
  logic cap_pin = 1'b0;
  logic xfer_ack = 1'b0;
  logic kick, ext_a, ext_b, req, we, accept, done, ok, ovf_irq, match_irq, cmp_match;
  logic udf_irq, cc_pin, pin_oe;
  logic [1:0] sel;
  logic [15:0] wdata, rdata, count, mcap, v, cval;
  logic [2:0] status;
  int error_cnt = 0;
  int check_count = 0;
  int cmp_seen = 0;
  int cyc = 0;
  int i, n, t0, t1, c0;
  tacl_note_t note_q[$];
  wire start = run | kick;

  always #4 sys_clk = ~sys_clk;

  tacl_timer_channel u_tacl_timer_channel (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .module_stop_i(module_stop), .count_start_i(start), .clock_src_i(clock_src),
    .presc_sel_i(2'h0), .clear_on_match_i(clear_match), .clear_on_capture_i(1'b0),
    .capture_mode_i(cap_mode), .buffer_mode_i(buf_mode), .cmp_out_en_i(cmp_en),
    .overflow_irq_enable_i(ovf_en), .underflow_irq_enable_i(udf_en),
    .match_irq_enable_i(match_en), .ext_clock_in_a_i(ext_a), .ext_clock_in_b_i(ext_b),
    .capture_pin_i(cap_pin), .xfer_ack_i(xfer_ack), .acc_req_i(req), .acc_we_i(we),
    .acc_sel_i(sel), .acc_wdata_i(wdata), .acc_accept_o(accept), .acc_done_o(done),
    .acc_rdata_o(rdata), .count_value_o(count), .match_capture_o(mcap),
    .timer_status_o(status), .overflow_irq_o(ovf_irq), .underflow_irq_o(udf_irq),
    .match_irq_o(match_irq), .cmp_match_o(cmp_match), .cc_pin_o(cc_pin), .cc_pin_oe_o(pin_oe));

  tacl_cpu_model u_tacl_cpu_model (.sys_clk_i(sys_clk), .acc_accept_i(accept),
    .acc_req_o(req), .acc_we_o(we), .acc_sel_o(sel), .acc_wdata_o(wdata),
    .kick_o(kick), .ext_a_o(ext_a), .ext_b_o(ext_b));

  // ==========================================================================
  // Compare and report
  // ==========================================================================
  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    chk16(what, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk)
    cyc <= cyc + 1;

  always @(negedge sys_clk)
  begin
    if (cmp_match === 1'b1)
      cmp_seen++;
    if (done === 1'b1)
    begin
      if (note_q.size() == 0)
        chk1("unexpected done", 1'b0, 1'b1);
      else if (note_q[0].rd)
        chk16("read data", note_q.pop_front().v, rdata);
      else
        void'(note_q.pop_front());
    end
  end

  // ==========================================================================
  // Stimulus helpers
  // ==========================================================================
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // For a read, v is the expected data; for a write, the data written.
  task automatic bus(input logic w, input logic [1:0] s, input logic [15:0] d, input logic k);
    note_q.push_back('{rd: ~w, v: d});
    u_tacl_cpu_model.access(w, s, d, k, ok);
    chk1("accepted", 1'b1, ok);
  endtask

  task automatic wait_cmp(output int t);
    for (n = 0; n < 2000; n++)
    begin
      @(negedge sys_clk);
      if (cmp_match === 1'b1)
        break;
    end
    t = cyc;
    if (n == 2000)
    begin
      error_cnt++;
      end_of_test();
    end
    else
      step(1);
  endtask

  initial
  begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h8D925DD0));
    step(6);
    rst_b = 1'b1;
    step(1);
    chk16("count reset", COUNT_RST, count);
    chk16("match reset", MATCH_RST, mcap);
    u_tacl_cpu_model.access(1'b1, SEL_COUNT, 16'h00AA, 1'b0, ok);
    chk1("stopped access", 1'b0, ok);
    module_stop = 1'b0;
    step(2);
    bus(1'b0, SEL_COUNT, COUNT_RST, 1'b0);
    $display("test stop done");

    v = 16'(3 + ($urandom % 14));
    clear_match = 1'b1;
    bus(1'b1, SEL_MATCH, v, 1'b0);
    run = 1'b1;
    wait_cmp(t0);
    wait_cmp(t1);
    run = 1'b0;
    chk16("period", v + 16'h0001, 16'(t1 - t0));
    $display("test period done");

    for (i = 0; i < 2; i++)
    begin
      clear_match = i[0];
      v = 16'($urandom);
      bus(1'b1, SEL_MATCH, MATCH_RST, 1'b0);
      bus(1'b1, SEL_COUNT, COUNT_MAX, 1'b0);
      bus(1'b1, SEL_COUNT, v, 1'b1);
      chk16("count after kick", (i == 1) ? COUNT_MIN : v, count);
      chk1("overflow flag", 1'b0, status[STAT_OVF_BIT]);
    end
    bus(1'b1, SEL_COUNT, 16'hFFFE, 1'b0);
    run = 1'b1;
    step(3);
    run = 1'b0;
    chk16("count after clear", 16'h0001, count);
    chk1("clear hides overflow", 1'b0, status[STAT_OVF_BIT]);
    $display("test write conflicts done");

    clear_match = 1'b0;
    ovf_en = 1'b1;
    match_en = 1'b1;
    bus(1'b1, SEL_COUNT, 16'hFFFE, 1'b0);
    run = 1'b1;
    step(3);
    run = 1'b0;
    step(1);
    chk1("ovf irq", 1'b1, ovf_irq);
    chk1("match irq", 1'b1, match_irq);
    ovf_en = 1'b0;
    step(1);
    chk1("ovf irq masked", 1'b0, ovf_irq);
    xfer_ack = 1'b1;
    step(1);
    xfer_ack = 1'b0;
    step(1);
    chk1("ack clears match", 1'b0, status[STAT_MATCH_BIT]);
    bus(1'b1, SEL_STATUS, 16'h0000, 1'b0);
    chk1("unarmed clear", 1'b1, status[STAT_OVF_BIT]);
    bus(1'b0, SEL_STATUS, 16'h0002, 1'b0);
    bus(1'b1, SEL_STATUS, 16'h0000, 1'b0);
    chk16("status cleared", 16'h0000, {13'h0000, status});
    $display("test flags done");

    bus(1'b1, SEL_MATCH, 16'h0100, 1'b0);
    bus(1'b1, SEL_COUNT, 16'h0100, 1'b0);
    c0 = cmp_seen;
    bus(1'b1, SEL_MATCH, 16'h0100, 1'b1);
    step(2);
    chk16("match pulses", 16'(c0), 16'(cmp_seen));
    chk1("match flag", 1'b0, status[STAT_MATCH_BIT]);
    buf_mode = 1'b1;
    v = 16'($urandom);
    bus(1'b1, SEL_MATCH, 16'h0200, 1'b0);
    bus(1'b1, SEL_COUNT, 16'h0200, 1'b0);
    bus(1'b1, SEL_BUFFER, v, 1'b1);
    chk16("buffer to match", v, mcap);
    $display("test compare conflicts done");

    cap_mode = 1'b1;
    cval = 16'($urandom);
    bus(1'b1, SEL_COUNT, cval, 1'b0);
    cap_pin = 1'b1;
    step(1);
    bus(1'b0, SEL_MATCH, cval, 1'b0);
    cap_pin = 1'b0;
    step(3);
    for (i = 0; i < 2; i++)
    begin
      buf_mode = i[0];
      bus(1'b1, SEL_MATCH, 16'h0A5A, 1'b0);
      cap_pin = 1'b1;
      bus(1'b1, (i == 1) ? SEL_BUFFER : SEL_MATCH, 16'h1111, 1'b0);
      cap_pin = 1'b0;
      bus(1'b0, SEL_MATCH, cval, 1'b0);
      if (i == 1)
        bus(1'b0, SEL_BUFFER, 16'h0A5A, 1'b0);
      step(3);
    end
    $display("test capture conflicts done");

    cap_mode = 1'b0;
    buf_mode = 1'b0;
    cmp_en = 1'b0;
    run = 1'b1;
    for (i = 1; i < 3; i++)
    begin
      clock_src = 2'(i);
      bus(1'b1, SEL_COUNT, 16'h0000, 1'b0);
      n = 2 + ($urandom % 5);
      u_tacl_cpu_model.ext_pulses(n);
      step(6);
      chk16("ext count", 16'(n * i), count);
    end
    clock_src = SRC_PHASE;
    udf_en = 1'b1;
    bus(1'b1, SEL_COUNT, 16'h0000, 1'b0);
    u_tacl_cpu_model.phase_steps(n, 1'b1);
    step(6);
    chk16("phase up count", 16'(n), count);
    u_tacl_cpu_model.phase_steps(n + 1, 1'b0);
    step(6);
    chk16("phase down count", COUNT_MAX, count);
    chk1("udf irq", 1'b1, udf_irq);
    chk1("pin oe", 1'b0, pin_oe);
    run = 1'b0;
    $display("test external clock done");

    chk1("cc pin", cmp_seen[0], cc_pin);
    match_en = 1'b0;
    module_stop = 1'b1;
    step(2);
    end_of_test();
  end
endmodule

// ==== verilog/tacl_access_seq.sv ====
`timescale 1ns/10ps
module tacl_access_seq
  import tacl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic req_i,
  output logic accept_o,
  output logic first_access_state_o,
  output logic second_access_state_o
);

  // ==========================================================================
  // Two-state access sequencer
  // ==========================================================================
  tacl_acc_state_t state_reg;
  tacl_acc_state_t state_next;

  assign accept_o = req_i & enable_i & (state_reg == ACC_IDLE);
  assign first_access_state_o = (state_reg == ACC_FIRST);
  assign second_access_state_o = (state_reg == ACC_SECOND);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ACC_IDLE: state_next = accept_o ? ACC_FIRST : ACC_IDLE;
      ACC_FIRST: state_next = ACC_SECOND;
      ACC_SECOND: state_next = ACC_IDLE;
      default: state_next = ACC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_reg <= ACC_IDLE;
    else
      state_reg <= state_next;
  end

endmodule

// ==== verilog/tacl_pin_edge.sv ====
`timescale 1ns/10ps
module tacl_pin_edge
  import tacl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  // ==========================================================================
  // Two-stage synchroniser and edge detect
  // ==========================================================================
  // Only the second and third stages feed logic; the first stage may go metastable.
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;

endmodule

// ==== verilog/tacl_pkg.sv ====
package tacl_pkg;

  // ==========================================================================
  // Data widths and reset values
  // ==========================================================================
  localparam int CNT_W = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] MATCH_RST = 16'hFFFF;
  localparam logic [15:0] BUFFER_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;

  // ==========================================================================
  // Processor access target select
  // ==========================================================================
  localparam logic [1:0] SEL_COUNT = 2'h0;
  localparam logic [1:0] SEL_MATCH = 2'h1;
  localparam logic [1:0] SEL_BUFFER = 2'h2;
  localparam logic [1:0] SEL_STATUS = 2'h3;

  // ==========================================================================
  // Status field positions
  // ==========================================================================
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_UDF_BIT = 2;
  localparam int STAT_W = 3;
  localparam logic [2:0] STATUS_RST = 3'h0;

  // ==========================================================================
  // Count source select and internal prescaler
  // ==========================================================================
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXT_SINGLE = 2'h1;
  localparam logic [1:0] SRC_EXT_BOTH = 2'h2;
  localparam logic [1:0] SRC_PHASE = 2'h3;
  localparam int PRESC_W = 6;
  localparam logic [5:0] PRESC_RST = 6'h00;

  // ==========================================================================
  // External clock limits, in half states of the peripheral clock
  // ==========================================================================
  localparam int EXT_MIN_SINGLE_HALF = 3;
  localparam int EXT_MIN_BOTH_HALF = 5;
  localparam int PHASE_MIN_GAP_HALF = 3;
  localparam int PHASE_MIN_WIDTH_HALF = 5;

  // Module stop is held asserted from reset until released.
  localparam logic STOP_RST = 1'b1;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_FIRST = 3'b010,
    ACC_SECOND = 3'b100
  } tacl_acc_state_t;

  // Prescaler terminal value: divide by 1, 4, 16 or 64.
  function automatic logic [5:0] presc_limit(input logic [1:0] sel);
    logic [5:0] lim;
    lim = 6'h00;
    case (sel)
      2'h0: lim = 6'h00;
      2'h1: lim = 6'h03;
      2'h2: lim = 6'h0F;
      default: lim = 6'h3F;
    endcase
    return lim;
  endfunction

endpackage

// ==== verilog/tacl_timer_channel.sv ====
`timescale 1ns/10ps
module tacl_timer_channel
  import tacl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic module_stop_i,
  input wire logic count_start_i,
  input wire logic [1:0] clock_src_i,
  input wire logic [1:0] presc_sel_i,
  input wire logic clear_on_match_i,
  input wire logic clear_on_capture_i,
  input wire logic capture_mode_i,
  input wire logic buffer_mode_i,
  input wire logic cmp_out_en_i,
  input wire logic overflow_irq_enable_i,
  input wire logic underflow_irq_enable_i,
  input wire logic match_irq_enable_i,
  input wire logic ext_clock_in_a_i,
  input wire logic ext_clock_in_b_i,
  input wire logic capture_pin_i,
  input wire logic xfer_ack_i,
  input wire logic acc_req_i,
  input wire logic acc_we_i,
  input wire logic [1:0] acc_sel_i,
  input wire logic [15:0] acc_wdata_i,
  output logic acc_accept_o,
  output logic acc_done_o,
  output logic [15:0] acc_rdata_o,
  output logic [15:0] count_value_o,
  output logic [15:0] match_capture_o,
  output logic [2:0] timer_status_o,
  output logic overflow_irq_o,
  output logic underflow_irq_o,
  output logic match_irq_o,
  output logic cmp_match_o,
  output logic cc_pin_o,
  output logic cc_pin_oe_o
);

  // ==========================================================================
  // Module stop and access sequencing
  // ==========================================================================
  logic stop_reg;
  logic t1;
  logic t2;
  logic acc_start;
  logic we_reg;
  logic [1:0] sel_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;

  tacl_access_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(~stop_reg),
    .req_i(acc_req_i),
    .accept_o(acc_start),
    .first_access_state_o(t1),
    .second_access_state_o(t2)
  );

  wire cnt_wr_t2 = t2 & we_reg & (sel_reg == SEL_COUNT);
  wire match_wr_t2 = t2 & we_reg & (sel_reg == SEL_MATCH);
  wire buf_wr_t2 = t2 & we_reg & (sel_reg == SEL_BUFFER);
  wire stat_wr_t2 = t2 & we_reg & (sel_reg == SEL_STATUS);
  wire read_t1 = t1 & ~we_reg;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Pulses narrower than the documented minimum can be missed by the sampler.
  logic a_lvl, a_rise, a_fall;
  logic b_lvl, b_rise, b_fall;
  logic cap_rise;

  tacl_pin_edge u_ext_a (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_clock_in_a_i),
    .level_o(a_lvl),
    .rise_o(a_rise),
    .fall_o(a_fall)
  );

  tacl_pin_edge u_ext_b (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_clock_in_b_i),
    .level_o(b_lvl),
    .rise_o(b_rise),
    .fall_o(b_fall)
  );

  tacl_pin_edge u_cap (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(capture_pin_i),
    .level_o(),
    .rise_o(cap_rise),
    .fall_o()
  );

  // ==========================================================================
  // Count source selection
  // ==========================================================================
  logic [5:0] presc_reg;
  wire run = ~stop_reg & count_start_i;
  wire presc_hit = (presc_reg >= presc_limit(presc_sel_i));
  wire [5:0] presc_next = presc_hit ? PRESC_RST : presc_reg + 6'h01;

  wire phase_up = (a_rise & ~b_lvl) | (a_fall & b_lvl) | (b_rise & a_lvl) | (b_fall & ~a_lvl);
  wire phase_dn = (a_rise & b_lvl) | (a_fall & ~b_lvl) | (b_rise & ~a_lvl) | (b_fall & a_lvl);

  logic src_tick;
  logic count_down;
  always_comb
  begin
    src_tick = 1'b0;
    count_down = 1'b0;
    unique case (clock_src_i)
      SRC_INTERNAL: src_tick = presc_hit;
      SRC_EXT_SINGLE: src_tick = a_rise;
      SRC_EXT_BOTH: src_tick = a_rise | a_fall;
      SRC_PHASE:
      begin
        src_tick = phase_up ^ phase_dn;
        count_down = phase_dn;
      end
    endcase
  end

  // ==========================================================================
  // Counter, compare and capture events
  // ==========================================================================
  logic [15:0] count_reg;
  logic [15:0] match_reg;
  logic [15:0] buffer_reg;
  logic [2:0] status_reg;
  logic [2:0] armed_reg;
  logic cmp_reg;
  logic pin_reg;

  wire tick = run & src_tick;
  wire cap_evt = ~stop_reg & capture_mode_i & cap_rise;
  wire match_hit = ~capture_mode_i & (count_reg == match_reg);
  // A second-state match write masks the match, whether or not the value changes.
  wire cmp_evt = tick & match_hit & ~match_wr_t2;
  wire clr_evt = (cmp_evt & clear_on_match_i) | (cap_evt & clear_on_capture_i);
  wire ovf_evt = tick & ~count_down & (count_reg == COUNT_MAX);
  wire udf_evt = tick & count_down & (count_reg == COUNT_MIN);
  wire ovf_set = ovf_evt & ~clr_evt & ~cnt_wr_t2;
  wire udf_set = udf_evt & ~clr_evt & ~cnt_wr_t2;

  logic [15:0] count_next;
  logic [15:0] match_next;
  logic [15:0] buffer_next;
  always_comb
  begin
    count_next = count_reg;
    if (clr_evt)
      count_next = COUNT_RST;
    else if (cnt_wr_t2)
      count_next = wdata_reg;
    else if (tick)
      count_next = count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
  end

  always_comb
  begin
    match_next = match_reg;
    if (cap_evt)
      match_next = count_reg;
    else if (match_wr_t2)
      match_next = wdata_reg;
    else if (cmp_evt & buffer_mode_i)
      match_next = buf_wr_t2 ? wdata_reg : buffer_reg;
  end

  always_comb
  begin
    buffer_next = buffer_reg;
    if (cap_evt & buffer_mode_i)
      buffer_next = match_reg;
    else if (buf_wr_t2)
      buffer_next = wdata_reg;
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  // Hardware set wins over any clear in the same cycle.
  wire [2:0] set_vec = {udf_set, ovf_set, cmp_evt | cap_evt};
  wire [2:0] clr_vec = ({3{stat_wr_t2}} & ~wdata_reg[2:0] & armed_reg)
    | {2'h0, xfer_ack_i};
  wire [2:0] status_next = (status_reg & ~clr_vec) | set_vec;

  logic [15:0] read_mux;
  always_comb
  begin
    read_mux = 16'h0000;
    unique case (sel_reg)
      SEL_COUNT: read_mux = count_next;
      SEL_MATCH: read_mux = match_next;
      SEL_BUFFER: read_mux = buffer_next;
      SEL_STATUS: read_mux = {13'h0000, status_next};
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stop_reg <= STOP_RST;
      we_reg <= 1'b0;
      sel_reg <= SEL_COUNT;
      wdata_reg <= COUNT_RST;
      rdata_reg <= COUNT_RST;
      presc_reg <= PRESC_RST;
    end
    else
    begin
      stop_reg <= module_stop_i;
      presc_reg <= run ? presc_next : PRESC_RST;
      if (acc_start)
      begin
        we_reg <= acc_we_i;
        sel_reg <= acc_sel_i;
        wdata_reg <= acc_wdata_i;
      end
      if (read_t1)
        rdata_reg <= read_mux;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_reg <= COUNT_RST;
      match_reg <= MATCH_RST;
      buffer_reg <= BUFFER_RST;
      status_reg <= STATUS_RST;
      armed_reg <= STATUS_RST;
      cmp_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      match_reg <= match_next;
      buffer_reg <= buffer_next;
      status_reg <= status_next;
      if (read_t1 && sel_reg == SEL_STATUS)
        armed_reg <= status_reg;
      else
        armed_reg <= armed_reg & ~clr_vec & status_next;
      cmp_reg <= cmp_evt;
      if (cmp_evt)
        pin_reg <= ~pin_reg;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign acc_accept_o = acc_start;
  assign acc_done_o = t2;
  assign acc_rdata_o = rdata_reg;
  assign count_value_o = count_reg;
  assign match_capture_o = match_reg;
  assign timer_status_o = status_reg;
  assign overflow_irq_o = status_reg[STAT_OVF_BIT] & overflow_irq_enable_i;
  assign underflow_irq_o = status_reg[STAT_UDF_BIT] & underflow_irq_enable_i;
  assign match_irq_o = status_reg[STAT_MATCH_BIT] & match_irq_enable_i;
  assign cmp_match_o = cmp_reg;
  assign cc_pin_o = pin_reg;
  // The pad is shared with an external clock input, so output is dropped then.
  assign cc_pin_oe_o = cmp_out_en_i & ~capture_mode_i & (clock_src_i == SRC_INTERNAL);

  // ==========================================================================
  // Checks
  // ==========================================================================
  stop_blocks_access_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    stop_reg |-> !acc_accept_o) else $error("access accepted while stopped");

  match_clears_count_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cmp_evt && clear_on_match_i) |=> (count_reg == 16'h0000))
    else $error("compare match did not clear the counter");

  clear_beats_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cnt_wr_t2 && clr_evt) |=> (count_reg == 16'h0000))
    else $error("counter write overrode a clear");

  write_beats_tick_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cnt_wr_t2 && !clr_evt) |=> (count_reg == $past(wdata_reg)))
    else $error("counter write lost");

  match_write_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    match_wr_t2 |=> !cmp_match_o) else $error("compare match during match write");

  capture_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (read_t1 && cap_evt && sel_reg == SEL_MATCH) |=> ##1 (acc_done_o == 1'b0)
      && (acc_rdata_o == $past(count_reg, 2)))
    else $error("read missed captured value");

  capture_beats_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (match_wr_t2 && cap_evt) |=> (match_reg == $past(count_reg)))
    else $error("match write overrode a capture");

  clear_hides_ovf_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (ovf_evt && clr_evt && !status_reg[STAT_OVF_BIT]) |=> !status_reg[STAT_OVF_BIT])
    else $error("overflow flagged despite clear");

  ovf_request_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (ovf_set && overflow_irq_enable_i) |=> overflow_irq_o || !overflow_irq_enable_i)
    else $error("overflow request missing");

  access_two_states_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    acc_accept_o |=> t1 ##1 (t2 && acc_done_o)) else $error("access not two states");

endmodule
